// ==== key_sink_model.sv ====
// Purpose: lookup-side model that takes each finished key
// Assumes: key_valid is a one-cycle pulse per key
// Notes:   counts keys so the bench can match requests
`timescale 1ns/100ps
module key_sink_model (
  // clock and key
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic key_valid,
  output int        key_count
);
  // count each key handed to the lookup
  always_ff @(posedge clk)
    key_count <= !rst_n ? 0 : key_count + int'(key_valid);
endmodule

// ==== key_tag_fields.sv ====
// Function
// - special-source mask layout used only when mask selector equals 3
// - mask bits 0..3 flag processor ports and virtual devices
// - bits 44..48 pipeline point, 49..51 pipeline action, bit 52 reserved
// - multicast flag equals destination MAC bit 40
// - broadcast flag set only for all-ones destination MAC
// - outer tag protocol code: 0 none, 1 8100, 4 88a8, 5-7 custom
// - outer priority/dei/vlan from frame, or classified when option set
// - untagged frame gives outer vlan zero
// - second tag protocol uses same codes, 0 when absent
// - second tag priority and dei copied straight from frame
// - second tag vlan copied straight from frame
// - third tag protocol uses same codes, 0 when absent
// - third tag priority, dei and vlan copied from frame
//
// Purpose: build ingress mask, MAC flags and tag fields of a lookup key
// Assumes: inputs valid with in_valid, synchronous to clk
// Notes:   one cycle latency; outputs are registers
//          fields keep the last key while no request is taken
`timescale 1ns/100ps
`include "key_tag_regs.svh"
module key_tag_fields #(
  parameter int NUM_TAGS = 3
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // frame parser and header
  input  wire logic                     in_valid,
  input  wire logic [1:0]               ingress_source_mask_selector,
  input  wire logic                     src_first_processor_port,
  input  wire logic                     src_second_processor_port,
  input  wire logic                     src_first_virtual_device,
  input  wire logic                     src_second_virtual_device,
  input  wire logic [5:0]               src_port_num,
  input  wire logic [4:0]               header_pipeline_point,
  input  wire logic [2:0]               header_pipeline_action,
  input  wire logic [`MASK_W-1:0]       plain_port_mask,
  input  wire logic [47:0]              dest_mac,
  // frame tags, index 0 outermost
  input  wire logic [NUM_TAGS-1:0]      tag_valid,
  input  wire logic [NUM_TAGS*16-1:0]   tag_tpid,
  input  wire logic [NUM_TAGS*3-1:0]    tag_pcp,
  input  wire logic [NUM_TAGS-1:0]      tag_dei,
  input  wire logic [NUM_TAGS*12-1:0]   tag_vid,
  // configuration
  input  wire logic [15:0]              custom_second_tag_protocol_code,
  input  wire logic [15:0]              custom_third_tag_protocol_code,
  input  wire logic [15:0]              custom_tpid3,
  input  wire logic                     use_classified_outer_tag_enable,
  input  wire logic [2:0]               classified_priority,
  input  wire logic                     classified_drop_eligible,
  input  wire logic [11:0]              classified_vlan,
  // key fields
  output logic                          key_valid,
  output logic [`MASK_W-1:0]            ingress_source_mask,
  output logic                          dest_mac_multicast_flag,
  output logic                          dest_mac_broadcast_flag,
  output logic [2:0]                    outer_tag_protocol_code,
  output logic [2:0]                    outer_tag_priority,
  output logic                          outer_tag_drop_eligible,
  output logic [11:0]                   outer_tag_vlan,
  output logic [2:0]                    second_tag_protocol_code,
  output logic [2:0]                    second_tag_priority,
  output logic                          second_tag_drop_eligible,
  output logic [11:0]                   second_tag_vlan,
  output logic [2:0]                    third_tag_protocol_code,
  output logic [2:0]                    third_tag_priority,
  output logic                          third_tag_drop_eligible,
  output logic [11:0]                   third_tag_vlan
);
  key_tag_pkg::tpid_code_t enc_code [NUM_TAGS];
  logic [2:0]              enc_pcp  [NUM_TAGS];
  logic                    enc_dei  [NUM_TAGS];
  logic [11:0]             enc_vid  [NUM_TAGS];

  // one encoder per tag position
  genvar g;
  generate
    for (g = 0; g < NUM_TAGS; g++)
    begin : g_tag
      tag_field_enc u_enc (
        .tag_valid    (tag_valid[g]),
        .tag_tpid     (tag_tpid[g*16 +: 16]),
        .tag_pcp      (tag_pcp[g*3 +: 3]),
        .tag_dei      (tag_dei[g]),
        .tag_vid      (tag_vid[g*12 +: 12]),
        .custom_second_tag_protocol_code (custom_second_tag_protocol_code),
        .custom_third_tag_protocol_code (custom_third_tag_protocol_code),
        .custom_tpid3 (custom_tpid3),
        .code         (enc_code[g]),
        .pcp          (enc_pcp[g]),
        .dei          (enc_dei[g]),
        .vid          (enc_vid[g])
      );
    end
  endgenerate

  // processor and virtual-device source flags in the low mask bits
  wire logic [`MASK_W-1:0] special_mask;
  assign special_mask[`MASK_BIT_FIRST_PROCESSOR_PORT]  = src_first_processor_port;
  assign special_mask[`MASK_BIT_SECOND_PROCESSOR_PORT]  = src_second_processor_port;
  assign special_mask[`MASK_BIT_VDEV0] = src_first_virtual_device;
  assign special_mask[`MASK_BIT_VDEV1] = src_second_virtual_device;

  // source port next to the flags; the gap up to the header fields reads zero
  assign special_mask[`MASK_SRC_MSB:`MASK_SRC_LSB] = src_port_num;
  assign special_mask[`MASK_PT_LSB-1:`MASK_SRC_MSB+1] = '0;

  // header pipeline fields on top; reserved bit kept zero so entries can ignore it
  assign special_mask[`MASK_PT_MSB:`MASK_PT_LSB]   = header_pipeline_point;
  assign special_mask[`MASK_ACT_MSB:`MASK_ACT_LSB] = header_pipeline_action;
  assign special_mask[`MASK_RSVD_BIT] = 1'b0;

  // mask select: only selector value 3 switches to the special layout
  wire logic              sel_special = (ingress_source_mask_selector == `MASK_SEL_SPECIAL);
  wire logic [`MASK_W-1:0] mask_d     = sel_special ? special_mask : plain_port_mask;

  // MAC flags from the group bit and an all-ones test
  wire logic              mc_d        = dest_mac[`MAC_MC_BIT];
  wire logic              bc_d        = &dest_mac;

  // outer presence, and priority and dei from the frame or the classified values
  wire logic        outer_present = (enc_code[0] != key_tag_pkg::tpid_none);
  wire logic [2:0]  outer_pcp_d = use_classified_outer_tag_enable ? classified_priority
                                                                  : enc_pcp[0];
  wire logic        outer_dei_d = use_classified_outer_tag_enable ? classified_drop_eligible
                                                                  : enc_dei[0];

  // outer vlan is zero for an untagged frame even when classified values are chosen
  wire logic [11:0] outer_vid_d = !outer_present ? 12'h000 :
                                  use_classified_outer_tag_enable ? classified_vlan
                                                                  : enc_vid[0];

  // one key valid pulse per taken request
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      key_valid <= 1'b0;
    end
    else
    begin
      key_valid <= in_valid;
    end
  end

  // mask and MAC flags, loaded when the parser presents a frame
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ingress_source_mask     <= '0;
      dest_mac_multicast_flag <= 1'b0;
      dest_mac_broadcast_flag <= 1'b0;
    end
    else if (in_valid)
    begin
      ingress_source_mask     <= mask_d;
      dest_mac_multicast_flag <= mc_d;
      dest_mac_broadcast_flag <= bc_d;
    end
  end

  // outer tag fields
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      outer_tag_protocol_code <= 3'h0;
      outer_tag_priority      <= 3'h0;
      outer_tag_drop_eligible <= 1'b0;
      outer_tag_vlan          <= 12'h000;
    end
    else if (in_valid)
    begin
      outer_tag_protocol_code <= enc_code[0];
      outer_tag_priority      <= outer_pcp_d;
      outer_tag_drop_eligible <= outer_dei_d;
      outer_tag_vlan          <= outer_vid_d;
    end
  end

  // second tag fields, straight from the frame
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      second_tag_protocol_code <= 3'h0;
      second_tag_priority      <= 3'h0;
      second_tag_drop_eligible <= 1'b0;
      second_tag_vlan          <= 12'h000;
    end
    else if (in_valid)
    begin
      second_tag_protocol_code <= enc_code[1];
      second_tag_priority      <= enc_pcp[1];
      second_tag_drop_eligible <= enc_dei[1];
      second_tag_vlan          <= enc_vid[1];
    end
  end

  // third tag fields, straight from the frame
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      third_tag_protocol_code <= 3'h0;
      third_tag_priority      <= 3'h0;
      third_tag_drop_eligible <= 1'b0;
      third_tag_vlan          <= 12'h000;
    end
    else if (in_valid)
    begin
      third_tag_protocol_code <= enc_code[2];
      third_tag_priority      <= enc_pcp[2];
      third_tag_drop_eligible <= enc_dei[2];
      third_tag_vlan          <= enc_vid[2];
    end
  end
endmodule

// ==== key_tag_fields_properties.sv ====
// Purpose: port checks on the key tag field builder
// Assumes: bound to key_tag_fields
// Notes:   one clock domain
`timescale 1ns/100ps
`include "key_tag_regs.svh"
module key_tag_fields_properties #(
  parameter int NUM_TAGS = 3
) (
  // clock, reset and request
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                in_valid,
  // source and frame inputs
  input wire logic [1:0]          ingress_source_mask_selector,
  input wire logic [5:0]          src_port_num,
  input wire logic [4:0]          header_pipeline_point,
  input wire logic [2:0]          header_pipeline_action,
  input wire logic [47:0]         dest_mac,
  input wire logic [NUM_TAGS-1:0] tag_valid,
  // key outputs
  input wire logic                key_valid,
  input wire logic [`MASK_W-1:0]  ingress_source_mask,
  input wire logic                dest_mac_multicast_flag,
  input wire logic                dest_mac_broadcast_flag,
  input wire logic [2:0]          outer_tag_protocol_code,
  input wire logic [11:0]         outer_tag_vlan
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a taken request in the special-source mask mode
  sequence s_special;
    in_valid && ingress_source_mask_selector == `MASK_SEL_SPECIAL;
  endsequence
  // assertions on the key outputs
  chk_key_valid_pulse: assert property (1'b1 |=> key_valid == $past(in_valid))
    else $error("key_valid does not follow in_valid");
  chk_special_src_port: assert property (s_special |=>
    ingress_source_mask[9:4] == $past(src_port_num))
    else $error("source port missing from mask");
  chk_special_header: assert property (s_special |=> ingress_source_mask[52:10] ==
    {1'b0, $past(header_pipeline_action), $past(header_pipeline_point), 34'h0})
    else $error("pipeline fields wrong in mask");
  chk_multicast_flag: assert property (in_valid |=>
    dest_mac_multicast_flag == $past(dest_mac[40]))
    else $error("multicast flag wrong");
  chk_broadcast_flag: assert property (in_valid |=>
    dest_mac_broadcast_flag == ($past(dest_mac) == '1))
    else $error("broadcast flag wrong");
  chk_untagged_outer: assert property (in_valid && !tag_valid[0] |=>
    outer_tag_vlan == 12'h0 && outer_tag_protocol_code == 3'h0)
    else $error("untagged frame gives outer fields");
  chk_fields_hold: assert property (!in_valid |=>
    $stable(ingress_source_mask) && $stable(outer_tag_vlan))
    else $error("key fields change without request");
  chk_code_legal: assert property (key_valid |->
    !(outer_tag_protocol_code inside {3'h2, 3'h3}))
    else $error("illegal outer protocol code");
endmodule
bind key_tag_fields key_tag_fields_properties #(.NUM_TAGS(NUM_TAGS)) i_props (
  .clk, .rst_n, .in_valid, .ingress_source_mask_selector, .src_port_num, .header_pipeline_point,
  .header_pipeline_action, .dest_mac, .tag_valid, .key_valid, .ingress_source_mask,
  .dest_mac_multicast_flag, .dest_mac_broadcast_flag, .outer_tag_protocol_code, .outer_tag_vlan);

// ==== key_tag_fields_tb.sv ====
// Purpose: random and corner test of the key tag field builder
// Assumes: inputs change at the falling edge
// Notes:   expected key rebuilt by bench functions
`timescale 1ns/100ps
`include "key_tag_regs.svh"
module key_tag_fields_tb;
  // stimulus and observed values
  logic clk = 1'b0, rst_n = 1'b0, iv = 1'b0, ucl = 1'b0, cd = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [3:0] sf = 4'h0;
  logic [5:0] src = 6'h0;
  logic [4:0] pt = 5'h0;
  logic [2:0] act = 3'h0, tv = 3'h0, td = 3'h0, cp = 3'h0;
  logic [8:0] tp = 9'h0;
  logic [11:0] cv = 12'h0;
  logic [35:0] tvd = 36'h0;
  logic [47:0] mac = 48'h0, tt = 48'h0;
  logic [`MASK_W-1:0] plain = '0, e_mask = '0;
  logic [1:0] e_fl = 2'h0;
  logic [56:0] e_tag = '0;
  logic [15:0] pick [6] = '{`TPID_STD, `TPID_PROV, 16'h9100, 16'h9200, 16'h9300, 16'h0800};
  logic [2:0] code_of [5] = '{3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
  wire kv, mc, bc;
  wire [`MASK_W-1:0] mask;
  wire [56:0] tf;
  int num_errors = 0, compares = 0, n_in = 0, keys;
  // design and lookup-side model
  key_tag_fields #(.NUM_TAGS(3)) i_dut (
    .clk(clk), .rst_n(rst_n), .in_valid(iv), .ingress_source_mask_selector(sel),
    .src_first_processor_port(sf[0]), .src_second_processor_port(sf[1]),
    .src_first_virtual_device(sf[2]), .src_second_virtual_device(sf[3]),
    .src_port_num(src), .header_pipeline_point(pt), .header_pipeline_action(act),
    .plain_port_mask(plain), .dest_mac(mac), .tag_valid(tv), .tag_tpid(tt), .tag_pcp(tp),
    .tag_dei(td), .tag_vid(tvd), .custom_second_tag_protocol_code(pick[2]), .custom_third_tag_protocol_code(pick[3]),
    .custom_tpid3(pick[4]), .use_classified_outer_tag_enable(ucl), .classified_priority(cp),
    .classified_drop_eligible(cd), .classified_vlan(cv), .key_valid(kv),
    .ingress_source_mask(mask), .dest_mac_multicast_flag(mc), .dest_mac_broadcast_flag(bc),
    .outer_tag_protocol_code(tf[18:16]), .outer_tag_priority(tf[15:13]),
    .outer_tag_drop_eligible(tf[12]), .outer_tag_vlan(tf[11:0]),
    .second_tag_protocol_code(tf[37:35]), .second_tag_priority(tf[34:32]),
    .second_tag_drop_eligible(tf[31]), .second_tag_vlan(tf[30:19]),
    .third_tag_protocol_code(tf[56:54]), .third_tag_priority(tf[53:51]),
    .third_tag_drop_eligible(tf[50]), .third_tag_vlan(tf[49:38]));
  key_sink_model i_sink (.clk(clk), .rst_n(rst_n), .key_valid(kv), .key_count(keys));
  // clock and watchdog
  always #50 clk = ~clk;
  initial
  begin
    #200000;
    num_errors++;
    stop_test();
  end
  // expected code and fields of tag k
  function automatic logic [18:0] tagx(input int k);
    logic [2:0] c;
    logic [2:0] p;
    logic d;
    logic [11:0] v;
    c = 3'h0;
    for (int j = 4; j >= 0; j--)
      if (tv[k] && tt[16*k+:16] == pick[j]) c = code_of[j];
    {p, d, v} = c != 3'h0 ? {tp[3*k+:3], td[k], tvd[12*k+:12]} : 16'h0;
    if (k == 0 && ucl) {p, d, v} = {cp, cd, c != 3'h0 ? cv : 12'h0};
    return {c, p, d, v};
  endfunction
  // drive one request, corners first
  task automatic drive(input int i);
    iv = i < 8 || $urandom_range(3) != 0;
    sel = i < 8 ? 2'(i) : 2'($urandom);
    {sf, src, pt, act} = 18'($urandom);
    plain = `MASK_W'({$urandom, $urandom});
    mac = i == 1 ? '1 : i == 2 ? 48'h010000000000 :
          i == 3 ? 48'hfffffffffffe : 48'({$urandom, $urandom});
    tv = i < 6 ? 3'h7 : i == 6 ? 3'h0 : 3'($urandom);
    for (int k = 0; k < 3; k++) tt[16*k+:16] = pick[i < 6 ? (i + k) % 6 : $urandom_range(5)];
    {tp, td, tvd, ucl, cp, cd, cv} = 65'({$urandom, $urandom, $urandom});
    if (iv) e_mask = sel == 2'h3 ? {1'b0, act, pt, 34'h0, src, sf} : plain;
    if (iv) e_fl = {mac[40], mac == '1};
    for (int k = 0; k < 3; k++) if (iv) e_tag[19*k+:19] = tagx(k);
  endtask
  // compare and report
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) num_errors++;
    if (seen !== exp) $display("mismatch %s expected %h seen %h", name, exp, seen);
  endtask
  task automatic check_all;
    check("key_valid", kv, iv);
    check("mask", mask, e_mask);
    check("mac flags", {mc, bc}, e_fl);
    check("outer tag", tf[18:0], e_tag[18:0]);
    check("second tag", tf[37:19], e_tag[37:19]);
    check("third tag", tf[56:38], e_tag[56:38]);
  endtask
  task stop_test;
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // reset, random run, a reset after the run, then a request right after release
  initial
  begin
    void'($urandom(32'h795f));
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    check_all();
    for (int i = 0; i < 400; i++)
    begin
      drive(i);
      @(negedge clk);
      check_all();
      n_in += int'(iv);
    end
    iv = 1'b0;
    @(negedge clk);
    check_all();
    check("key count", keys, n_in);
    {rst_n, iv, e_mask, e_fl, e_tag} = '0;
    @(negedge clk);
    check_all();
    rst_n = 1'b1;
    drive(3);
    @(negedge clk);
    check_all();
    stop_test();
  end
endmodule

// ==== key_tag_pkg.sv ====
// Purpose: types for the classifier key tag field builder
// Assumes: nothing
// Notes:   code points of the 3-bit tag protocol field
package key_tag_pkg;
  typedef enum logic [2:0] {
    tpid_none    = 3'h0,
    tpid_std     = 3'h1,
    tpid_prov    = 3'h4,
    tpid_custom1 = 3'h5,
    tpid_custom2 = 3'h6,
    tpid_custom3 = 3'h7
  } tpid_code_t;
endpackage

// ==== key_tag_regs.svh ====
// Purpose: constants for the classifier key tag field builder
// Assumes: included by bare name
// Notes:   definitions only
`ifndef KEY_TAG_REGS_SVH
`define KEY_TAG_REGS_SVH
`define MASK_W            53
`define MASK_SEL_SPECIAL  2'h3
`define MASK_BIT_FIRST_PROCESSOR_PORT     0
`define MASK_BIT_SECOND_PROCESSOR_PORT     1
`define MASK_BIT_VDEV0    2
`define MASK_BIT_VDEV1    3
`define MASK_SRC_LSB      4
`define MASK_SRC_MSB      9
`define MASK_PT_LSB       44
`define MASK_PT_MSB       48
`define MASK_ACT_LSB      49
`define MASK_ACT_MSB      51
`define MASK_RSVD_BIT     52
`define MAC_MC_BIT        40
`define TPID_STD          16'h8100
`define TPID_PROV         16'h88a8
`endif

// ==== tag_field_enc.sv ====
// Purpose: encode one frame tag into key fields
// Assumes: tag_valid marks a tag present in the frame
// Notes:   combinational; registered by the parent
`timescale 1ns/100ps
`include "key_tag_regs.svh"
module tag_field_enc (
  // tag from the parser
  input  wire logic                    tag_valid,
  input  wire logic [15:0]             tag_tpid,
  input  wire logic [2:0]              tag_pcp,
  input  wire logic                    tag_dei,
  input  wire logic [11:0]             tag_vid,
  // configurable custom protocol values
  input  wire logic [15:0]             custom_second_tag_protocol_code,
  input  wire logic [15:0]             custom_third_tag_protocol_code,
  input  wire logic [15:0]             custom_tpid3,
  // encoded fields
  output key_tag_pkg::tpid_code_t      code,
  output logic [2:0]                   pcp,
  output logic                         dei,
  output logic [11:0]                  vid
);
  wire logic is_std  = (tag_tpid == `TPID_STD);
  wire logic is_prov = (tag_tpid == `TPID_PROV);
  wire logic is_c1   = (tag_tpid == custom_second_tag_protocol_code);
  wire logic is_c2   = (tag_tpid == custom_third_tag_protocol_code);
  wire logic is_c3   = (tag_tpid == custom_tpid3);
  wire logic known   = tag_valid & (is_std | is_prov | is_c1 | is_c2 | is_c3);

  // code selection; unknown or absent tag gives 0, never 2 or 3
  assign code = !known  ? key_tag_pkg::tpid_none :
                is_std  ? key_tag_pkg::tpid_std :
                is_prov ? key_tag_pkg::tpid_prov :
                is_c1   ? key_tag_pkg::tpid_custom1 :
                is_c2   ? key_tag_pkg::tpid_custom2 :
                          key_tag_pkg::tpid_custom3;
  // absent tag fields read zero
  assign pcp = known ? tag_pcp : 3'h0;
  assign dei = known & tag_dei;
  assign vid = known ? tag_vid : 12'h000;
endmodule
